// *** src/voice_port_pkg.sv ***
// constants shared by the voice message playback port
// assumes a 100 MHz core clock; all times are converted to cycles here
package voice_port_pkg;
   // ----------------------------------------------------------------
   // address space
   // ----------------------------------------------------------------
   localparam int          ADDR_W      = 10;
   localparam logic [9:0]  ADDR_LAST   = 10'h257;
   localparam int          ADDR_COUNT  = 600;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          CLK_HZ      = 100000000;
   localparam int          SAMPLE_HZ   = 8000;
   localparam int          SAMPLE_DIV  = CLK_HZ / SAMPLE_HZ;
   localparam real         END_PULSE_MS = 12.5;
   localparam int          END_PULSE_CYC =
      int'(END_PULSE_MS * real'(CLK_HZ) / 1000.0);
   // samples held per address: 480k cells over 600 addresses
   localparam int          SAMPLES_PER_ADDR = 800;
   localparam int          SAMPLE_CNT_W = 10;
   // stored message-end marker value
   localparam logic [7:0]  MARKER_CODE = 8'hff;
endpackage

// *** src/rate_divider.sv ***
// one-cycle enable pulse every DIV clocks
// assumes a synchronous active-low reset and a free-running clock
`timescale 1ns/1ps
module rate_divider #(
   parameter int DIV = 12500
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      tick
);
   logic [31:0] count_reg;
   wire         atEnd = (count_reg == 32'(DIV - 1));

   always_ff @(posedge core_clk) begin
      if (!rst_n || !run) begin
         count_reg <= 32'h0;
         tick      <= 1'b0;
      end else begin
         count_reg <= atEnd ? 32'h0 : count_reg + 32'h1;
         tick      <= atEnd;
      end
   end
endmodule

// *** src/voice_message_port.sv ***
// host-facing control logic of the voice record/playback device
// assumes all pins are synchronous to core_clk; audio path is abstracted
// to an 8-bit sample in and out, marker storage is one flag per address
`timescale 1ns/1ps
module voice_message_port #(
   parameter int END_PULSE_CYC = voice_port_pkg::END_PULSE_CYC,
   parameter int SAMPLE_DIV    = voice_port_pkg::SAMPLE_DIV,
   parameter int SAMPLES_PER_ADDR = voice_port_pkg::SAMPLES_PER_ADDR
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [9:0] message_address_lines,
   input  wire logic       enable_n,
   input  wire logic       sleep_request,
   input  wire logic       play_record_sel,
   input  wire logic [7:0] sample_in,
   output logic [7:0]      sample_out,
   output logic            message_end_pulse_n,
   output logic            storage_full_n,
   output logic            busy
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {IDLE, RECORD, PLAY, HOLD} state_t;
   state_t state_reg;
   state_t state_next;

   logic [9:0]  addr_reg;
   logic [9:0]  sampleCnt_reg;
   logic [31:0] endCnt_reg;
   logic [7:0]  lastSample_reg;
   logic        marker_reg [0:voice_port_pkg::ADDR_COUNT-1];
   logic        tick;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire addrValid = (message_address_lines <= voice_port_pkg::ADDR_LAST);
   wire canStart  = !sleep_request && !enable_n && addrValid;
   wire running   = (state_reg == RECORD) || (state_reg == PLAY);
   wire addrDone  = tick &&
      (sampleCnt_reg == 10'(SAMPLES_PER_ADDR - 1));
   wire atLast    = (addr_reg == voice_port_pkg::ADDR_LAST);
   wire memEnd    = addrDone && atLast;
   // releasing enable ends a recording; marker is written there
   wire recStop   = (state_reg == RECORD) && (enable_n || memEnd);
   wire playMark  = (state_reg == PLAY) && addrDone && marker_reg[addr_reg];
   wire msgEnd    = recStop || playMark || ((state_reg == PLAY) && memEnd);
   wire pulseOn   = (endCnt_reg != 32'h0);

   rate_divider #(
      .DIV (SAMPLE_DIV)
   ) u_sample_rate (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (running),
      .tick     (tick)
   );

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         IDLE: begin
            if (canStart) begin
               state_next = play_record_sel ? RECORD : PLAY;
            end
         end
         RECORD, PLAY: begin
            if (sleep_request) begin
               state_next = IDLE;
            end else if (msgEnd) begin
               state_next = HOLD;
            end
         end
         HOLD: begin
            // a held-low enable must not relaunch before the pulse ends
            if (!pulseOn && enable_n) begin
               state_next = IDLE;
            end
         end
         default: state_next = IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // address and sample counting
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_reg      <= 10'h0;
         sampleCnt_reg <= 10'h0;
      end else if (state_reg == IDLE) begin
         addr_reg      <= message_address_lines;
         sampleCnt_reg <= 10'h0;
      end else if (running && tick) begin
         sampleCnt_reg <= addrDone ? 10'h0 : sampleCnt_reg + 10'h1;
         if (addrDone && !atLast) begin
            addr_reg <= addr_reg + 10'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // marker storage; one sample word stands in for the analog cells
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lastSample_reg <= 8'h0;
      end else if (state_reg == RECORD && tick) begin
         lastSample_reg <= sample_in;
      end
   end

   // flags are cleared at reset so that playing an unrecorded address
   // reads a known value instead of letting an unknown reach the pins
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < voice_port_pkg::ADDR_COUNT; i++) begin
            marker_reg[i] <= 1'b0;
         end
      end else begin
         if (state_reg == RECORD && tick) begin
            marker_reg[addr_reg] <= 1'b0;
         end
         // a stop in the same cycle as a sample keeps the marker
         if (recStop) begin
            marker_reg[addr_reg] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         endCnt_reg <= 32'h0;
      end else if (msgEnd) begin
         endCnt_reg <= 32'(END_PULSE_CYC);
      end else if (pulseOn) begin
         endCnt_reg <= endCnt_reg - 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // output decode
   // ----------------------------------------------------------------
   // the pin falls with the end event itself, on the same edge that
   // loads the counter, so the low time is exactly END_PULSE_CYC
   wire       endPinNext = !(msgEnd || (endCnt_reg > 32'h1));
   wire       fullSet    = memEnd && running;
   wire       fullClear  = (state_reg == IDLE) && canStart;
   wire [7:0] playSample = (state_reg == PLAY) ? lastSample_reg : 8'h0;
   wire       busyNext   = (state_next != IDLE);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         message_end_pulse_n <= 1'b1;
      end else begin
         message_end_pulse_n <= endPinNext;
      end
   end

   // full latches until the next accepted start, so a cascaded part
   // can see it long after this one has gone idle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         storage_full_n <= 1'b1;
      end else if (fullSet) begin
         storage_full_n <= 1'b0;
      end else if (fullClear) begin
         storage_full_n <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sample_out <= 8'h0;
      end else begin
         sample_out <= playSample;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= busyNext;
      end
   end
endmodule

// *** verification/voice_port_chk.sv ***
// pin-level assertions for the voice message port
// bound to voice_message_port, sees its ports only
`timescale 1ns/1ps
module voice_port_chk #(
   parameter int END_PULSE_CYC = 20
) (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic [9:0] message_address_lines,
   input wire logic       enable_n,
   input wire logic       sleep_request,
   input wire logic       play_record_sel,
   input wire logic       message_end_pulse_n,
   input wire logic       storage_full_n,
   input wire logic       busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] lowCnt_reg;
   // counted, since the full-length pulse is far too long to unroll
   always_ff @(posedge core_clk)
      if (!rst_n || message_end_pulse_n) lowCnt_reg <= 32'h0;
      else lowCnt_reg <= lowCnt_reg + 32'h1;
   sequence go; !busy && !enable_n && !sleep_request &&
      message_address_lines <= 10'h257; endsequence
   sequence recEnd; busy && play_record_sel && $rose(enable_n); endsequence
   start_busy_a: assert property (go |=> busy)
      else $error("start not taken");
   no_start_a: assert property (!busy && enable_n |=> !busy)
      else $error("start while disabled");
   bad_addr_a: assert property (
      message_address_lines > 10'h257 && !busy |=> !busy)
      else $error("bad address taken");
   sleep_idle_a: assert property (sleep_request |=> !busy)
      else $error("busy while asleep");
   pulse_len_a: assert property (
      $rose(message_end_pulse_n) |-> lowCnt_reg == END_PULSE_CYC)
      else $error("end pulse width wrong");
   rec_end_a: assert property (recEnd |=> !message_end_pulse_n)
      else $error("no end pulse after record");
   full_hold_a: assert property (
      !busy |=> busy || $stable(storage_full_n)) else $error("full moved");
   go_clear_a: assert property (go |=> storage_full_n)
      else $error("full not cleared");
endmodule
bind voice_message_port voice_port_chk #(.END_PULSE_CYC(END_PULSE_CYC))
   i_voice_port_chk (.core_clk(core_clk), .rst_n(rst_n),
   .message_address_lines(message_address_lines), .enable_n(enable_n),
   .sleep_request(sleep_request), .play_record_sel(play_record_sel),
   .message_end_pulse_n(message_end_pulse_n),
   .storage_full_n(storage_full_n), .busy(busy));

// *** verification/host_model.sv ***
// host controller model driving the voice port control pins
// run is called from one bench process at a time
`timescale 1ns/1ps
module host_model (
   input  wire logic  core_clk,
   input  wire logic  message_end_pulse_n,
   output logic [9:0] message_address_lines,
   output logic       enable_n,
   output logic       play_record_sel,
   output logic       sleep_request
);
   logic [1:0] endSync_reg;
   initial begin
      message_address_lines = 10'h000;
      enable_n = 1'b1;
      play_record_sel = 1'b0;
      sleep_request = 1'b0;
      endSync_reg = 2'h3;
   end
   // two flops before edge detection, as a real host would need
   always @(posedge core_clk)
      endSync_reg <= {endSync_reg[0], message_end_pulse_n};
   task automatic run(input logic [9:0] a, input logic r, input logic s,
         input int hold, output int lat);
      @(negedge core_clk);
      sleep_request = s;
      play_record_sel = r;
      message_address_lines = a;
      @(negedge core_clk);
      enable_n = 1'b0;
      repeat (hold) @(negedge core_clk);
      enable_n = 1'b1;
      lat = 0;
      while (endSync_reg[1] && lat < 200) begin
         @(negedge core_clk);
         lat++;
      end
      while (!endSync_reg[1]) @(negedge core_clk);
   endtask
endmodule

// *** verification/tb_voice_message_port.sv ***
// bench for voice_message_port with the host model on its pins
// short pulse and rate parameters keep the run brief
`timescale 1ns/1ps
`define CHK(n, e, a) begin nChecks++; if ((a) !== (e)) begin errors++; \
   $display("Error %s exp %0h got %0h", n, e, a); end end
module tb_voice_message_port;
   logic       core_clk, rst_n, enN, sel, slp, endN, fullN, busy, seen;
   logic [9:0] adr;
   logic [7:0] smpOut;
   int         errors = 0;
   int         nChecks = 0;
   int         lat;
   host_model i_host_model (.core_clk(core_clk), .message_end_pulse_n(endN),
      .message_address_lines(adr), .enable_n(enN), .play_record_sel(sel),
      .sleep_request(slp));
   voice_message_port #(.END_PULSE_CYC(20), .SAMPLE_DIV(4),
      .SAMPLES_PER_ADDR(2)) i_voice_message_port (.core_clk(core_clk),
      .rst_n(rst_n), .message_address_lines(adr), .enable_n(enN),
      .sleep_request(slp), .play_record_sel(sel), .sample_in(8'h5a),
      .sample_out(smpOut), .message_end_pulse_n(endN),
      .storage_full_n(fullN), .busy(busy));
   always @(posedge core_clk) if (busy && smpOut === 8'h5a) seen <= 1'b1;
   task automatic close_out;
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_rec_play;
      i_host_model.run(10'h010, 1'b1, 1'b0, 6, lat);
      `CHK("rec end", 1, lat < 200)
      seen = 1'b0;
      i_host_model.run(10'h010, 1'b0, 1'b0, 10, lat);
      `CHK("play end", 1, lat < 200)
      `CHK("play out", 1'b1, seen)
   endtask
   task automatic t_refuse;
      i_host_model.run(10'h258, 1'b0, 1'b0, 10, lat);
      `CHK("bad addr", 200, lat)
      i_host_model.run(10'h020, 1'b0, 1'b1, 10, lat);
      `CHK("asleep", 200, lat)
   endtask
   task automatic t_full;
      i_host_model.run(10'h257, 1'b0, 1'b0, 10, lat);
      `CHK("full", 1'b0, fullN)
      i_host_model.run(10'h010, 1'b0, 1'b0, 10, lat);
      `CHK("cleared", 1'b1, fullN)
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      rst_n = 1'b0;
      seen = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      `CHK("rst full", 1'b1, fullN)
      t_rec_play();
      t_refuse();
      t_full();
      close_out();
   end
   initial begin
      #200000;
      errors++;
      close_out();
   end
endmodule
